// File: include/sri_pkg.sv
package sri_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_RSEL = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_SADDR = 8'h14;
  localparam logic [7:0] OFS_SDATA = 8'h18;
  localparam logic [7:0] OFS_VEC = 8'h1C;

  // Command word fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DST_LSB = 4;
  localparam int CMD_PTR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  // Status word fields.
  localparam int STS_PC_LSB = 0;
  localparam int STS_IE = 12;
  localparam int STS_C = 13;
  localparam int STS_Z = 14;
  localparam int STS_BANK = 15;
  localparam int STS_DEPTH_LSB = 16;
  localparam int STS_PEND = 24;
  localparam int STS_BUSY = 25;

  // Flags word fields.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_BANK = 2;

  localparam int PC_W = 12;
  localparam int RF_SIZE = 32;
  localparam int STACK_LEVELS = 30;
  localparam logic [4:0] STACK_FULL = 5'h1E;
  localparam logic [4:0] STACK_EMPTY = 5'h00;
  localparam int SPM_SIZE_DEF = 64;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [11:0] VEC_RST = 12'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_FETCH_IMM = 3'h1,
    OP_FETCH_PTR = 3'h2,
    OP_IRQ_ALLOW = 3'h3,
    OP_IRQ_BLOCK = 3'h4,
    OP_RET_EN = 3'h5,
    OP_RET_DIS = 3'h6,
    OP_IRQ = 3'h7
  } sri_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EX1 = 2'h1,
    ST_EX2 = 2'h3
  } sri_state_e;

endpackage

// File: include/sri_spm_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sri_spm_if;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] ld_addr;
  logic [7:0] ld_data;
  logic [7:0] wr_data;
  logic wr_en;
  modport core(output rd_addr, ld_addr, wr_data, wr_en,
               input rd_data, ld_data);
  modport mem(input rd_addr, ld_addr, wr_data, wr_en,
              output rd_data, ld_data);
endinterface
`default_nettype wire

// File: src/sri_scratch.sv
`timescale 1ns/10ps
`default_nettype none
module sri_scratch
  import sri_pkg::*;
#(
  parameter int SPM_SIZE = SPM_SIZE_DEF
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  sri_spm_if.mem spm
);

  localparam int AW = $clog2(SPM_SIZE);

  logic [7:0] mem_q [SPM_SIZE];
  logic [AW-1:0] rd_idx;
  logic [AW-1:0] ld_idx;

  // Upper address bits are dropped, so wide addresses alias downwards.
  assign rd_idx = spm.rd_addr[AW-1:0];
  assign ld_idx = spm.ld_addr[AW-1:0];

  for (genvar g = 0; g < SPM_SIZE; g++) begin : g_entry
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        mem_q[g] <= 8'h00;
      end else if (spm.wr_en && ld_idx == AW'(g)) begin
        mem_q[g] <= spm.wr_data;
      end
    end
  end

  // Reads are pure muxes and never disturb the array.
  assign spm.rd_data = mem_q[rd_idx];
  assign spm.ld_data = mem_q[ld_idx];

  alias_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    spm.wr_en |=> mem_q[$past(ld_idx)] == $past(spm.wr_data))
    else $error("Scratch write did not land at the aliased entry.");

  read_keeps_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !spm.wr_en |=> mem_q[$past(rd_idx)] == $past(spm.rd_data))
    else $error("Scratch contents changed without a write.");

endmodule
`default_nettype wire

// File: src/sri_core.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Fetch copies a scratch byte to a register, address immediate or pointer.
// - Fetch leaves scratch contents and carry and zero flags untouched.
// - Scratch memory defaults to 64 bytes, addresses 00 to 3F.
// - A build parameter selects 128 or 256 bytes instead.
// - Only low address bits matching the size are used; upper bits alias.
// - Reset starts at address zero with interrupts disabled.
// - With interrupts disabled a high request is ignored.
// - Irq-allow sets the enable flag and nothing else.
// - Irq-block clears the enable flag and nothing else.
// - Repeating allow or block just keeps the flag value.
// - Taking an interrupt abandons the instruction, pushes its address.
// - Taking an interrupt also saves carry, zero, bank and clears enable.
// - Isr-return pops the saved address back into the program counter.
// - Isr-return restores carry, zero and bank selection.
// - Isr-return sets or clears the enable flag per its opcode.
// - Every instruction takes exactly two clock cycles.
// - Stack holds 30 levels; overflow or underflow forces internal reset.
module sri_core
  import sri_pkg::*;
#(
  parameter int SPM_SIZE = SPM_SIZE_DEF
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  output logic irq_accept
);

  sri_spm_if spm ();

  sri_state_e st_q;
  sri_state_e st_d;
  sri_op_e op_q;
  logic [3:0] dst_q;
  logic [3:0] ptr_q;
  logic [7:0] imm_q;
  logic [31:0] cmd_q;
  logic pend_q;
  logic [11:0] pc_q;
  logic [11:0] vec_q;
  logic ie_q;
  logic ie_d;
  logic c_q;
  logic z_q;
  logic bank_q;
  logic [4:0] depth_q;
  logic [4:0] top_idx;
  logic [11:0] stk_pc_q [STACK_LEVELS];
  logic [2:0] stk_f_q [STACK_LEVELS];
  logic [11:0] top_pc;
  logic [2:0] top_f;
  logic [7:0] rf_q [RF_SIZE];
  logic [4:0] dst_idx;
  logic [4:0] rsel_q;
  logic [7:0] saddr_q;
  logic irq_s1_q;
  logic irq_s2_q;
  logic irq_s3_q;
  logic irq_lvl_q;
  logic ex2;
  logic is_ret;
  logic is_fetch;
  logic boundary;
  logic srst;
  logic irq_take;
  logic cmd_start;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic cmd_wr;
  logic flg_wr;
  logic [31:0] wval;
  logic [1:0] wresp;

  function automatic logic reg_ok(input logic [7:0] a);
    return a == OFS_CMD || a == OFS_STATUS || a == OFS_FLAGS ||
           a == OFS_RSEL || a == OFS_RDATA || a == OFS_SADDR ||
           a == OFS_SDATA || a == OFS_VEC;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == OFS_CMD) begin
      v = cmd_q;
    end else if (a == OFS_STATUS) begin
      v[STS_PC_LSB +: PC_W] = pc_q;
      v[STS_IE] = ie_q;
      v[STS_C] = c_q;
      v[STS_Z] = z_q;
      v[STS_BANK] = bank_q;
      v[STS_DEPTH_LSB +: 5] = depth_q;
      v[STS_PEND] = pend_q;
      v[STS_BUSY] = st_q != ST_IDLE;
    end else if (a == OFS_FLAGS) begin
      v[FLG_C] = c_q;
      v[FLG_Z] = z_q;
      v[FLG_BANK] = bank_q;
    end else if (a == OFS_RSEL) begin
      v[4:0] = rsel_q;
    end else if (a == OFS_RDATA) begin
      v[7:0] = rf_q[rsel_q];
    end else if (a == OFS_SADDR) begin
      v[7:0] = saddr_q;
    end else if (a == OFS_SDATA) begin
      v[7:0] = spm.ld_data;
    end else if (a == OFS_VEC) begin
      v[PC_W-1:0] = vec_q;
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  sri_scratch #(
    .SPM_SIZE(SPM_SIZE)
  ) u_scratch (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .spm(spm.mem)
  );

  // The request pin is asynchronous to sys_clk.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      irq_s3_q <= 1'b0;
      irq_lvl_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_req;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (irq_s2_q == irq_s3_q) begin
        irq_lvl_q <= irq_s3_q;
      end
    end
  end

  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  // A process keeps the merge sensitive to every register the read reaches.
  always_comb begin
    wval = merge(reg_read(aw_addr_q), w_data_q, w_strb_q);
  end
  assign cmd_wr = wr_go && aw_addr_q == OFS_CMD && !pend_q;
  assign flg_wr = wr_go && aw_addr_q == OFS_FLAGS;

  always_comb begin
    wresp = RESP_OKAY;
    if (!reg_ok(aw_addr_q)) begin
      wresp = RESP_SLVERR;
    end else if (aw_addr_q == OFS_CMD && pend_q) begin
      wresp = RESP_SLVERR;
    end
  end

  assign ex2 = st_q == ST_EX2;
  assign boundary = st_q == ST_IDLE || ex2;
  assign is_ret = op_q == OP_RET_EN || op_q == OP_RET_DIS;
  assign is_fetch = op_q == OP_FETCH_IMM || op_q == OP_FETCH_PTR;
  assign top_idx = depth_q - 5'h01;
  assign top_pc = stk_pc_q[top_idx];
  assign top_f = stk_f_q[top_idx];
  assign dst_idx = {bank_q, dst_q};
  assign srst = ex2 && ((op_q == OP_IRQ && depth_q == STACK_FULL) ||
                        (is_ret && depth_q == STACK_EMPTY));

  // The flag seen by the boundary already includes this instruction.
  always_comb begin
    ie_d = ie_q;
    if (srst) begin
      ie_d = 1'b0;
    end else if (ex2) begin
      case (op_q)
        OP_IRQ_ALLOW: ie_d = 1'b1;
        OP_IRQ_BLOCK: ie_d = 1'b0;
        OP_RET_EN: ie_d = 1'b1;
        OP_RET_DIS: ie_d = 1'b0;
        OP_IRQ: ie_d = 1'b0;
        default: ie_d = ie_q;
      endcase
    end
  end

  assign irq_take = boundary && !srst && irq_lvl_q && ie_d;
  assign cmd_start = boundary && !srst && pend_q && !irq_take;

  always_comb begin
    case (st_q)
      ST_EX1: st_d = ST_EX2;
      ST_IDLE, ST_EX2: begin
        st_d = (irq_take || cmd_start) ? ST_EX1 : ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      ie_q <= 1'b0;
      irq_accept <= 1'b0;
    end else begin
      st_q <= st_d;
      ie_q <= ie_d;
      irq_accept <= irq_take;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      op_q <= OP_NOP;
      dst_q <= 4'h0;
      ptr_q <= 4'h0;
      imm_q <= 8'h00;
    end else if (irq_take) begin
      op_q <= OP_IRQ;
    end else if (cmd_start) begin
      op_q <= sri_op_e'(cmd_q[CMD_OP_LSB +: 3]);
      if (cmd_q[CMD_OP_LSB +: 3] == OP_IRQ) begin
        op_q <= OP_NOP;
      end
      dst_q <= cmd_q[CMD_DST_LSB +: 4];
      ptr_q <= cmd_q[CMD_PTR_LSB +: 4];
      imm_q <= cmd_q[CMD_IMM_LSB +: 8];
    end
  end

  // An accepted interrupt drops the waiting command; software reissues it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      cmd_q <= 32'h0000_0000;
    end else if (cmd_wr) begin
      pend_q <= 1'b1;
      cmd_q <= wval;
    end else if (cmd_start || irq_take || srst) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PC_RST;
    end else if (srst) begin
      pc_q <= PC_RST;
    end else if (ex2) begin
      if (op_q == OP_IRQ) begin
        pc_q <= vec_q;
      end else if (is_ret) begin
        pc_q <= top_pc;
      end else begin
        pc_q <= pc_q + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      c_q <= 1'b0;
      z_q <= 1'b0;
      bank_q <= 1'b0;
    end else if (srst) begin
      c_q <= 1'b0;
      z_q <= 1'b0;
      bank_q <= 1'b0;
    end else if (ex2 && is_ret) begin
      {bank_q, z_q, c_q} <= top_f;
    end else if (flg_wr && !ex2) begin
      c_q <= wval[FLG_C];
      z_q <= wval[FLG_Z];
      bank_q <= wval[FLG_BANK];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      depth_q <= STACK_EMPTY;
      for (int i = 0; i < STACK_LEVELS; i++) begin
        stk_pc_q[i] <= PC_RST;
        stk_f_q[i] <= 3'h0;
      end
    end else if (srst) begin
      depth_q <= STACK_EMPTY;
    end else if (ex2 && op_q == OP_IRQ) begin
      depth_q <= depth_q + 5'h01;
      stk_pc_q[depth_q] <= pc_q;
      stk_f_q[depth_q] <= {bank_q, z_q, c_q};
    end else if (ex2 && is_ret) begin
      depth_q <= top_idx;
    end
  end

  assign spm.rd_addr = (op_q == OP_FETCH_PTR) ?
                       rf_q[{bank_q, ptr_q}] : imm_q;
  assign spm.ld_addr = saddr_q;
  assign spm.wr_en = wr_go && aw_addr_q == OFS_SDATA;
  assign spm.wr_data = wval[7:0];

  // A fetch in its last cycle wins over a software write to the bank.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RF_SIZE; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else if (ex2 && is_fetch) begin
      rf_q[dst_idx] <= spm.rd_data;
    end else if (wr_go && aw_addr_q == OFS_RDATA) begin
      rf_q[rsel_q] <= wval[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsel_q <= 5'h00;
      saddr_q <= 8'h00;
      vec_q <= VEC_RST;
    end else if (wr_go) begin
      if (aw_addr_q == OFS_RSEL) begin
        rsel_q <= wval[4:0];
      end else if (aw_addr_q == OFS_SADDR) begin
        saddr_q <= wval[7:0];
      end else if (aw_addr_q == OFS_VEC) begin
        vec_q <= wval[PC_W-1:0];
      end
    end
  end

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wresp;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= reg_read(s_axi_araddr);
      rresp_q <= reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  two_cycle_a: assert property (
    (irq_take || cmd_start) |=> st_q == ST_EX1 ##1 st_q == ST_EX2)
    else $error("Instruction did not take exactly two cycles.");

  fetch_load_a: assert property (
    (ex2 && is_fetch) |=> rf_q[$past(dst_idx)] == $past(spm.rd_data))
    else $error("Fetch did not load the scratch byte.");

  fetch_flags_a: assert property (
    (ex2 && is_fetch && !flg_wr) |=> $stable(c_q) && $stable(z_q))
    else $error("Fetch altered the carry or zero flag.");

  allow_ie_a: assert property (
    (ex2 && op_q == OP_IRQ_ALLOW) |=>
      ie_q && pc_q == $past(pc_q) + 12'h001)
    else $error("Allow did not set the flag and advance.");

  block_ie_a: assert property (
    (ex2 && op_q == OP_IRQ_BLOCK) |=> !ie_q [*2])
    else $error("Block did not clear the enable flag.");

  irq_ignore_a: assert property (
    (st_q == ST_IDLE && !ie_q && !pend_q) |=> st_q == ST_IDLE)
    else $error("Request taken while interrupts disabled.");

  irq_push_a: assert property (
    (ex2 && op_q == OP_IRQ && depth_q != STACK_FULL) |=>
      pc_q == $past(vec_q) && !ie_q &&
      depth_q == $past(depth_q) + 5'h01 &&
      stk_pc_q[$past(depth_q)] == $past(pc_q))
    else $error("Interrupt entry did not push and vector.");

  ret_pop_a: assert property (
    (ex2 && op_q == OP_RET_EN && depth_q != STACK_EMPTY) |=>
      pc_q == $past(top_pc) && {bank_q, z_q, c_q} == $past(top_f) &&
      ie_q)
    else $error("Return did not restore the saved context.");

  stack_reset_a: assert property (
    (ex2 && op_q == OP_IRQ && depth_q == STACK_FULL) |=>
      pc_q == PC_RST && depth_q == STACK_EMPTY && !ie_q)
    else $error("Stack overflow did not force a reset.");

  irq_edge_a: assert property (
    irq_accept |-> st_q == ST_EX1 && op_q == OP_IRQ)
    else $error("Interrupt accepted off an instruction boundary.");

endmodule
`default_nettype wire

// File: dv/sri_irq_src.sv
`timescale 1ns/10ps
`default_nettype none
// Requesting peripheral: a fire strobe raises the request, which then
// stands until the core accepts it, so a request met by blocked
// interrupts stays pending.
module sri_irq_src (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fire,
  input wire logic irq_accept,
  output logic irq_req
);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_req <= 1'b0;
    end else if (irq_accept) begin
      irq_req <= 1'b0;
    end else if (fire) begin
      irq_req <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: dv/sri_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sri_core_tb_top
  import sri_pkg::*;
;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rstn, fire;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, strb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq_req, irq_accept;
  int miscompares = 0;
  int n_tests = 0;
  int n_acc = 0;
  int cyc = 0;

  always #4 sys_clk = ~sys_clk;

  sri_core #(.SPM_SIZE(64)) u_sri_core (
    .sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_req(irq_req),
    .irq_accept(irq_accept)
  );

  sri_irq_src u_sri_irq_src (
    .sys_clk(sys_clk), .rstn(rstn), .fire(fire),
    .irq_accept(irq_accept), .irq_req(irq_req)
  );

  task report_and_stop;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge sys_clk) begin
    cyc++;
    if (irq_accept === 1'b1) n_acc++;
    if (cyc == LIMIT) begin
      miscompares++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task rdw(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  function automatic logic [31:0] cmd(input sri_op_e op,
                                      input logic [3:0] dst,
                                      input logic [3:0] ptr,
                                      input logic [7:0] imm);
    return {8'h00, imm, 4'h0, ptr, dst, 1'b0, op};
  endfunction

  task wait_sts(input logic [31:0] m, input logic [31:0] v);
    do rdw(OFS_STATUS); while ((rd & m) !== v);
  endtask

  task run(input logic [31:0] c);
    wr(OFS_CMD, c);
    wait_sts(32'h0300_0000, 32'h0000_0000);
  endtask

  task rreg(input logic [31:0] i);
    wr(OFS_RSEL, i);
    rdw(OFS_RDATA);
  endtask

  task pulse_fire;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask

  task t_reset;
    rdw(OFS_STATUS);
    chk(rd, 32'h0000_0000, "status after reset");
    rdw(8'h20);
    chk(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    wr(8'h20, 32'h0000_00FF);
    chk(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    wr(OFS_RSEL, 32'h0000_0000);
    chk(32'(rsp), 32'(RESP_OKAY), "mapped write");
    $display("test reset done");
  endtask

  task t_fetch;
    wr(OFS_SADDR, 32'h0000_002A);
    wr(OFS_SDATA, 32'h0000_005C);
    wr(OFS_SADDR, 32'h0000_003F);
    wr(OFS_SDATA, 32'h0000_00A7);
    wr(OFS_FLAGS, 32'h0000_0003);
    // No byte lane enabled, so the flags must keep their value.
    strb = 4'h0;
    wr(OFS_FLAGS, 32'h0000_0000);
    strb = 4'hF;
    wr(OFS_RSEL, 32'h0000_0004);
    wr(OFS_RDATA, 32'h0000_003F);
    // Address 6A keeps only its low six bits, 2A, in a 64-byte memory.
    run(cmd(OP_FETCH_IMM, 4'h3, 4'h0, 8'h6A));
    run(cmd(OP_FETCH_PTR, 4'h5, 4'h4, 8'h00));
    rreg(32'h0000_0003);
    chk(rd, 32'h0000_005C, "aliased immediate fetch");
    rreg(32'h0000_0005);
    chk(rd, 32'h0000_00A7, "pointer fetch top byte");
    rdw(OFS_STATUS);
    chk(32'(rd[14:13]), 32'h0000_0003, "flags kept by fetch");
    chk(32'(rd[11:0]), 32'h0000_0002, "pc after two");
    wr(OFS_SADDR, 32'h0000_002A);
    rdw(OFS_SDATA);
    chk(rd, 32'h0000_005C, "scratch kept by fetch");
    $display("test fetch done");
  endtask

  task t_enable;
    sri_op_e ops[4];
    logic exp[4];
    ops = '{OP_IRQ_ALLOW, OP_IRQ_ALLOW, OP_IRQ_BLOCK, OP_IRQ_BLOCK};
    exp = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      run(cmd(ops[i], 4'h0, 4'h0, 8'h00));
      rdw(OFS_STATUS);
      chk(32'(rd[12]), 32'(exp[i]), "enable flag");
      chk(32'(rd[14:13]), 32'h0000_0003, "flags kept");
    end
    pulse_fire;
    repeat (20) @(posedge sys_clk);
    chk(32'(n_acc), 32'h0000_0000, "request while blocked");
    rdw(OFS_STATUS);
    chk(32'(rd[20:0]), 32'h0000_6006, "no entry while blocked");
    $display("test enable done");
  endtask

  task t_irq;
    wr(OFS_VEC, 32'h0000_0123);
    wr(OFS_FLAGS, 32'h0000_0005);
    wr(OFS_CMD, cmd(OP_IRQ_ALLOW, 4'h0, 4'h0, 8'h00));
    wait_sts(32'h031F_0000, 32'h0001_0000);
    chk(32'(n_acc), 32'h0000_0001, "accept pulse");
    chk(32'(rd[11:0]), 32'h0000_0123, "vector loaded");
    chk(32'(rd[12]), 32'h0000_0000, "enable cleared");
    wr(OFS_FLAGS, 32'h0000_0000);
    run(cmd(OP_RET_EN, 4'h0, 4'h0, 8'h00));
    rdw(OFS_STATUS);
    chk(32'(rd[11:0]), 32'h0000_0007, "resume address");
    chk(32'(rd[15:13]), 32'h0000_0005, "flags restored");
    chk(32'(rd[12]), 32'h0000_0001, "return enables");
    chk(32'(rd[20:16]), 32'h0000_0000, "stack popped");
    pulse_fire;
    wait_sts(32'h031F_0000, 32'h0001_0000);
    run(cmd(OP_RET_DIS, 4'h0, 4'h0, 8'h00));
    rdw(OFS_STATUS);
    chk(32'(rd[12]), 32'h0000_0000, "return disables");
    chk(32'(rd[11:0]), 32'h0000_0007, "second resume");
    wr(OFS_FLAGS, 32'h0000_0000);
    $display("test irq done");
  endtask

  task t_stack;
    run(cmd(OP_IRQ_ALLOW, 4'h0, 4'h0, 8'h00));
    run(cmd(OP_RET_EN, 4'h0, 4'h0, 8'h00));
    rdw(OFS_STATUS);
    chk(32'(rd[20:0]), 32'h0000_0000, "underflow reset");
    rreg(32'h0000_0005);
    chk(rd, 32'h0000_00A7, "registers survive");
    for (int i = 0; i < STACK_LEVELS; i++) begin
      pulse_fire;
      wr(OFS_CMD, cmd(OP_IRQ_ALLOW, 4'h0, 4'h0, 8'h00));
      wait_sts(32'h031F_0000, {11'h000, 5'(i + 1), 16'h0000});
    end
    chk(32'(rd[11:0]), 32'h0000_0123, "nested entry");
    pulse_fire;
    wr(OFS_CMD, cmd(OP_IRQ_ALLOW, 4'h0, 4'h0, 8'h00));
    wait_sts(32'h031F_1FFF, 32'h0000_0000);
    chk(32'(rd[20:0]), 32'h0000_0000, "overflow reset");
    run(cmd(OP_IRQ, 4'h0, 4'h0, 8'h00));
    rdw(OFS_STATUS);
    chk(32'(rd[20:0]), 32'h0000_0001, "code seven runs as nop");
    $display("test stack done");
  endtask

  initial begin
    rstn = 1'b0;
    fire = 1'b0;
    strb = 4'hF;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_fetch;
    t_enable;
    t_irq;
    t_stack;
    report_and_stop;
  end
endmodule
`default_nettype wire
